//--- qrf_queue_device.v
// Purpose: store of many queues with read pipeline, status buses and packet mode
// Assumes: all port pins are synchronous to clk_sys, except the packet strap
// Notes: one clock serves both the write and the read side
//
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "qrf_consts.vh"

////////////////////////////////////////////////////////////////////////////////
// How it works
// - queue switch forces one old-queue word, then one new-queue word
// - status buses four or eight bits; small parts show every queue continuously
// - large parts show status directly addressed or polled
// - polled mode sends group per cycle, sync high with first group
// - empty bus timed like the full bus, with its own sync
// - packet mode only on 36-bit words, chosen during master reset
// - packet mode gives ready flag; empty bus carries ready status
// - bits 35, 34, 33 mark end, start, near end of packet
// - end marks counted in and out per queue give ready status
// - packet mode: no word leaves a queue without a complete packet
// - packet mode switch outputs old then new word regardless of enable
module qrf_queue_device
#(
  parameter NQ = 32,
  parameter QW = 5,
  parameter DEPTH = 8,
  parameter PW = 3,
  parameter DW = 36,
  parameter BW = 8,
  parameter GW = 2
)
(
  // clock and master reset
  input wire clk_sys,
  input wire rst,
  input wire packet_mode_strap,
  // write port
  input wire wr_en_n,
  input wire wr_addr_en,
  input wire [QW-1:0] write_queue_address,
  input wire [DW-1:0] data_in,
  // read port
  input wire rd_en_n,
  input wire rd_addr_en,
  input wire [QW-1:0] read_queue_address,
  output reg [DW-1:0] data_out,
  output reg output_valid_n,
  output reg packet_ready_flag_n,
  // status buses
  output wire [BW-1:0] almost_full_status_bus_n,
  output wire full_bus_sync,
  output wire [BW-1:0] almost_empty_status_bus_n,
  output wire empty_bus_sync,
  // register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata
);

  localparam ST_IDLE = 3'b001;
  localparam ST_OLD = 3'b010;
  localparam ST_NEW = 3'b100;

  ////////////////////////////////////////////////////////////////////////////////
  // configuration and mode

  reg [2:0] ctrl;
  reg [7:0] paf_off;
  reg [7:0] pae_off;
  reg pkt_mode;
  wire strap_s;

  qrf_sync2 u_strap
  (
    .clk_sys(clk_sys),
    .rst(1'b0),
    .level_in(packet_mode_strap),
    .level_out(strap_s)
  );

  // mode is only caught while master reset is held, so it cannot change in flight
  always @(posedge clk_sys)
  begin
    if (rst)
      pkt_mode <= strap_s && (DW == `QRF_PKT_WIDTH);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // per-queue storage and counters

  reg [QW-1:0] wq;
  reg [QW-1:0] rq;
  reg [QW-1:0] new_q;
  reg [2:0] sw_state;
  reg do_pop;
  reg next_valid_n;
  wire do_wr;
  wire [NQ-1:0] avail_v;
  wire [NQ-1:0] full_v;
  wire [NQ-1:0] af_v;
  wire [NQ-1:0] ae_v;
  wire [NQ-1:0] rdy_v;
  wire [NQ*DW-1:0] head_v;
  wire [DW-1:0] head;

  assign do_wr = !wr_en_n && !full_v[wq];
  assign head = head_v[rq*DW +: DW];

  genvar g;
  generate
    for (g = 0; g < NQ; g = g + 1)
    begin : g_q
      reg [DW-1:0] mem [0:DEPTH-1];
      reg [PW-1:0] wp;
      reg [PW-1:0] rp;
      reg [PW:0] cnt;
      reg [PW:0] pkts;
      wire wr_hit;
      wire rd_hit;
      wire end_in;
      wire end_out;
      wire [8:0] fsum;

      assign wr_hit = do_wr && (wq == g);
      assign rd_hit = do_pop && (rq == g);
      assign end_in = wr_hit && data_in[`QRF_END_BIT];
      assign end_out = rd_hit && mem[rp][`QRF_END_BIT];
      assign fsum = {1'b0, paf_off} + {{(8-PW){1'b0}}, cnt};
      assign full_v[g] = (cnt == DEPTH);
      assign af_v[g] = (fsum >= DEPTH);
      assign ae_v[g] = ({{(7-PW){1'b0}}, cnt} <= pae_off);
      assign rdy_v[g] = (pkts != {(PW+1){1'b0}});
      // a partial packet is never offered to the read pipeline
      assign avail_v[g] = (cnt != {(PW+1){1'b0}}) && (!pkt_mode || rdy_v[g]);
      assign head_v[g*DW +: DW] = mem[rp];

      always @(posedge clk_sys)
      begin
        if (wr_hit)
          mem[wp] <= data_in;
      end

      always @(posedge clk_sys)
      begin
        if (rst)
        begin
          wp <= {PW{1'b0}};
          rp <= {PW{1'b0}};
          cnt <= {(PW+1){1'b0}};
          pkts <= {(PW+1){1'b0}};
        end
        else
        begin
          if (wr_hit)
            wp <= wp + 1'b1;
          if (rd_hit)
            rp <= rp + 1'b1;
          if (wr_hit && !rd_hit)
            cnt <= cnt + 1'b1;
          else if (!wr_hit && rd_hit)
            cnt <= cnt - 1'b1;
          if (end_in && !end_out)
            pkts <= pkts + 1'b1;
          else if (!end_in && end_out)
            pkts <= pkts - 1'b1;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // write queue selection

  always @(posedge clk_sys)
  begin
    if (rst)
      wq <= {QW{1'b0}};
    else if (wr_addr_en)
      wq <= write_queue_address;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read pipeline

  always @*
  begin
    do_pop = 1'b0;
    next_valid_n = output_valid_n;
    case (sw_state)
      ST_OLD:
      begin
        // last word of the old queue leaves whatever read enable says
        do_pop = avail_v[rq];
        next_valid_n = !avail_v[rq];
      end
      ST_NEW:
      begin
        // first word of the new queue falls through
        do_pop = avail_v[rq];
        next_valid_n = !avail_v[rq];
      end
      default:
      begin
        // enabled read, or fall-through into an empty output stage
        if (output_valid_n || !rd_en_n)
        begin
          do_pop = avail_v[rq];
          next_valid_n = !avail_v[rq];
        end
      end
    endcase
  end

  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      sw_state <= ST_IDLE;
      rq <= {QW{1'b0}};
      new_q <= {QW{1'b0}};
      data_out <= {DW{1'b0}};
      output_valid_n <= 1'b1;
    end
    else
    begin
      output_valid_n <= next_valid_n;
      if (do_pop)
        data_out <= head;
      case (sw_state)
        ST_IDLE:
        begin
          if (rd_addr_en)
          begin
            new_q <= read_queue_address;
            sw_state <= ST_OLD;
          end
        end
        ST_OLD:
        begin
          // a select during the purge cycle is ignored
          rq <= new_q;
          sw_state <= ST_NEW;
        end
        ST_NEW:
        begin
          if (rd_addr_en)
          begin
            new_q <= read_queue_address;
            sw_state <= ST_OLD;
          end
          else
            sw_state <= ST_IDLE;
        end
        default:
          sw_state <= ST_IDLE;
      endcase
    end
  end

  always @(posedge clk_sys)
  begin
    if (rst)
      packet_ready_flag_n <= 1'b1;
    else
      packet_ready_flag_n <= !(pkt_mode && rdy_v[rq]);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // status buses

  wire [NQ-1:0] empty_side;

  // in packet mode the empty bus is reused for per-queue ready status
  assign empty_side = pkt_mode ? rdy_v : ae_v;

  qrf_flag_mux #(.NQ(NQ), .BW(BW), .GW(GW)) u_full_bus
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .polled(ctrl[`QRF_CTRL_POLL_BIT]),
    .group_sel(ctrl[`QRF_CTRL_GSEL_MSB:`QRF_CTRL_GSEL_LSB]),
    .flags(af_v),
    .bus_n(almost_full_status_bus_n),
    .sync(full_bus_sync)
  );

  qrf_flag_mux #(.NQ(NQ), .BW(BW), .GW(GW)) u_empty_bus
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .polled(ctrl[`QRF_CTRL_POLL_BIT]),
    .group_sel(ctrl[`QRF_CTRL_GSEL_MSB:`QRF_CTRL_GSEL_LSB]),
    .flags(empty_side),
    .bus_n(almost_empty_status_bus_n),
    .sync(empty_bus_sync)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // register port

  reg [31:0] rdy_word;
  reg [31:0] af_word;

  always @*
  begin
    rdy_word = 32'h0;
    af_word = 32'h0;
    rdy_word[NQ-1:0] = rdy_v;
    af_word[NQ-1:0] = af_v;
  end

  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      ctrl <= `QRF_CTRL_RST;
      paf_off <= `QRF_PAF_RST;
      pae_off <= `QRF_PAE_RST;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `QRF_CTRL_OFS)
        ctrl <= reg_wdata[2:0];
      else if (reg_addr == `QRF_OFFS_OFS)
      begin
        paf_off <= reg_wdata[`QRF_OFFS_PAF_MSB:`QRF_OFFS_PAF_LSB];
        pae_off <= reg_wdata[`QRF_OFFS_PAE_MSB:`QRF_OFFS_PAE_LSB];
      end
    end
  end

  // read data stands for exactly one cycle; unmapped addresses read zero
  always @(posedge clk_sys)
  begin
    if (rst)
      reg_rdata <= 32'h0;
    else if (!reg_rd)
      reg_rdata <= 32'h0;
    else if (reg_addr == `QRF_CTRL_OFS)
      reg_rdata <= {29'h0, ctrl};
    else if (reg_addr == `QRF_OFFS_OFS)
      reg_rdata <= {16'h0, pae_off, paf_off};
    else if (reg_addr == `QRF_STAT_OFS)
      reg_rdata <= {11'h0, wq, 3'h0, rq, 3'h0, sw_state, pkt_mode, output_valid_n};
    else if (reg_addr == `QRF_PRDY_OFS)
      reg_rdata <= rdy_word;
    else if (reg_addr == `QRF_AFUL_OFS)
      reg_rdata <= af_word;
    else
      reg_rdata <= 32'h0;
  end

endmodule

//--- qrf_consts.vh
// Purpose: shared offsets, fields, reset values and marker positions of the queue device
// Assumes: included by bare name from the device file and the bench
// Notes: definitions only
`ifndef QRF_CONSTS_VH
`define QRF_CONSTS_VH

////////////////////////////////////////////////////////////////////////////////
// register byte offsets
`define QRF_CTRL_OFS 8'h00
`define QRF_OFFS_OFS 8'h04
`define QRF_STAT_OFS 8'h08
`define QRF_PRDY_OFS 8'h0C
`define QRF_AFUL_OFS 8'h10

////////////////////////////////////////////////////////////////////////////////
// control fields
`define QRF_CTRL_POLL_BIT 0
`define QRF_CTRL_GSEL_LSB 1
`define QRF_CTRL_GSEL_MSB 2
`define QRF_CTRL_RST 3'h1

// offset fields
`define QRF_OFFS_PAF_LSB 0
`define QRF_OFFS_PAF_MSB 7
`define QRF_OFFS_PAE_LSB 8
`define QRF_OFFS_PAE_MSB 15
`define QRF_PAF_RST 8'h02
`define QRF_PAE_RST 8'h02

////////////////////////////////////////////////////////////////////////////////
// packet markers in the data word
`define QRF_PKT_WIDTH 36
`define QRF_END_BIT 35
`define QRF_START_BIT 34
`define QRF_NEAR_END_BIT 33

`endif

//--- qrf_sync2.v
// Purpose: two-flop synchroniser for a level from a pin
// Assumes: single clock clk_sys
// Notes: only the second stage may be read
`timescale 1ns/1ps

module qrf_sync2
(
  // clock and reset
  input wire clk_sys,
  input wire rst,
  // level in and out
  input wire level_in,
  output reg level_out
);

  reg stage1;

  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      stage1 <= 1'b0;
      level_out <= 1'b0;
    end
    else
    begin
      stage1 <= level_in;
      level_out <= stage1;
    end
  end

endmodule

//--- qrf_flag_mux.v
// Purpose: drives one status bus, continuous, polled or direct
// Assumes: NQ is a multiple of BW; GW bits hold NQ/BW-1
// Notes: bus is active low, sync marks the first group in polled mode
`timescale 1ns/1ps

module qrf_flag_mux
#(
  parameter NQ = 32,
  parameter BW = 8,
  parameter GW = 2
)
(
  // clock and reset
  input wire clk_sys,
  input wire rst,
  // mode and per-queue flags (active high)
  input wire polled,
  input wire [GW-1:0] group_sel,
  input wire [NQ-1:0] flags,
  // bus out
  output reg [BW-1:0] bus_n,
  output reg sync
);

  localparam NG = NQ / BW;

  reg [GW-1:0] idx;

  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      idx <= {GW{1'b0}};
      bus_n <= {BW{1'b1}};
      sync <= 1'b0;
    end
    else if (NG == 1)
    begin
      // small parts: every queue always visible
      bus_n <= ~flags[BW-1:0];
      sync <= 1'b0;
    end
    else if (polled)
    begin
      bus_n <= ~flags[idx*BW +: BW];
      sync <= (idx == {GW{1'b0}});
      if (idx == NG - 1)
        idx <= {GW{1'b0}};
      else
        idx <= idx + 1'b1;
    end
    else
    begin
      bus_n <= ~flags[group_sel*BW +: BW];
      sync <= 1'b0;
      idx <= {GW{1'b0}};
    end
  end

endmodule

//--- qrf_chk_asserts.sv
// Purpose: port checks of the queue device read side, status syncs and register port
// Assumes: one clock, synchronous active high reset
// Notes: bound to every device instance
`timescale 1ns/1ps

module qrf_chk
#(
  parameter DW = 36
)
(
  // clock and reset
  input wire clk_sys,
  input wire rst,
  // read port
  input wire rd_en_n,
  input wire rd_addr_en,
  input wire [DW-1:0] data_out,
  input wire output_valid_n,
  // syncs and registers
  input wire full_bus_sync,
  input wire empty_bus_sync,
  input wire [7:0] reg_addr,
  input wire reg_rd,
  input wire [31:0] reg_rdata
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  sync_space_a: assert property (full_bus_sync |=> !full_bus_sync [*3])
    else $error("full sync repeated inside one poll round");
  sync_pair_a: assert property (full_bus_sync == empty_bus_sync)
    else $error("empty sync not aligned with full sync");
  purge_old_a: assert property (
    rd_addr_en |-> ##2 (output_valid_n || data_out != $past(data_out)))
    else $error("no old queue word after select");
  purge_new_a: assert property (
    rd_addr_en |-> ##3 (output_valid_n || data_out != $past(data_out)))
    else $error("no new queue word after select");
  // a valid word may only be lost by an enabled read or a purge
  valid_rise_a: assert property (
    $rose(output_valid_n) |-> !$past(rd_en_n) || $past(rd_addr_en, 2) || $past(rd_addr_en, 3))
    else $error("valid flag dropped without a read");
  out_hold_a: assert property (
    $past(rd_en_n) && !$past(output_valid_n) && !$past(rd_addr_en, 2) && !$past(rd_addr_en, 3)
    |-> $stable(data_out))
    else $error("output word changed without a read");
  rdata_stand_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  unmapped_rd_a: assert property ($past(reg_rd) && $past(reg_addr) > 8'h10 |-> reg_rdata == 32'h0)
    else $error("unmapped read returned data");
endmodule

bind qrf_queue_device qrf_chk #(.DW(DW)) chk
(
  .clk_sys(clk_sys), .rst(rst), .rd_en_n(rd_en_n), .rd_addr_en(rd_addr_en),
  .data_out(data_out), .output_valid_n(output_valid_n), .full_bus_sync(full_bus_sync),
  .empty_bus_sync(empty_bus_sync), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata)
);

//--- qrf_reader.sv
// Purpose: reading controller model: new word detection and status image
// Assumes: watches the read port and one status bus
// Notes: take is settled before the edge at which the word is used
`timescale 1ns/1ps

module qrf_reader
(
  // clock and reset
  input wire clk_sys,
  input wire rst,
  // read port
  input wire rd_en_n,
  input wire rd_addr_en,
  input wire output_valid_n,
  // status bus
  input wire [7:0] bus_n,
  input wire bus_sync,
  // results
  output wire take,
  output reg [1:0] age,
  output reg [31:0] image
);
  reg last_ren_n;
  reg last_valid_n;
  reg [1:0] idx;
  assign take = !output_valid_n && (!last_ren_n || last_valid_n || age == 2'h1 || age == 2'h2);
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      last_ren_n <= 1'b1;
      last_valid_n <= 1'b1;
      age <= 2'h3;
      idx <= 2'h3;
      image <= 32'hFFFFFFFF;
    end
    else
    begin
      last_ren_n <= rd_en_n;
      last_valid_n <= output_valid_n;
      if (rd_addr_en)
        age <= 2'h0;
      else if (age != 2'h3)
        age <= age + 2'h1;
      if (bus_sync)
      begin
        image[7:0] <= bus_n;
        idx <= 2'h0;
      end
      else if (idx != 2'h3)
      begin
        image[{idx + 2'h1, 3'h0} +: 8] <= bus_n;
        idx <= idx + 2'h1;
      end
    end
  end
endmodule

//--- queue_read_flag_monitor_tb_top.sv
// Purpose: self-checking bench for the queue device
// Assumes: default sizes, 32 queues of depth 8
// Notes: every taken word is checked against per-queue models
`timescale 1ns/1ps
`include "qrf_consts.vh"

module queue_read_flag_monitor_tb_top;
  reg clk_sys = 1'b0;
  reg rst = 1'b1;
  reg packet_mode_strap = 1'b0;
  reg wr_en_n = 1'b1;
  reg wr_addr_en = 1'b0;
  reg rd_en_n = 1'b1;
  reg rd_addr_en = 1'b0;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg [4:0] write_queue_address = 5'h00;
  reg [4:0] read_queue_address = 5'h00;
  reg [35:0] data_in = 36'h0;
  reg [7:0] reg_addr = 8'h00;
  reg [31:0] reg_wdata = 32'h0;
  reg [31:0] r;
  reg [31:0] ae_exp;
  reg [31:0] af_exp;
  reg [35:0] w;
  reg [35:0] mq [32][$];
  wire [35:0] data_out;
  wire output_valid_n, packet_ready_flag_n, full_bus_sync, empty_bus_sync, take;
  wire [7:0] af_bus_n, ae_bus_n;
  wire [31:0] reg_rdata, ae_img, af_img;
  wire [1:0] age;
  integer n_errors = 0, checks = 0, seed = 32'h6ea0, wq = 0, cur_q = 0, prev_q = 0, i, k, q;

  qrf_queue_device DUT
  (
    .clk_sys(clk_sys), .rst(rst), .packet_mode_strap(packet_mode_strap),
    .wr_en_n(wr_en_n), .wr_addr_en(wr_addr_en), .write_queue_address(write_queue_address),
    .data_in(data_in), .rd_en_n(rd_en_n), .rd_addr_en(rd_addr_en),
    .read_queue_address(read_queue_address), .data_out(data_out),
    .output_valid_n(output_valid_n), .packet_ready_flag_n(packet_ready_flag_n),
    .almost_full_status_bus_n(af_bus_n), .full_bus_sync(full_bus_sync),
    .almost_empty_status_bus_n(ae_bus_n), .empty_bus_sync(empty_bus_sync),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata)
  );
  qrf_reader pe (.clk_sys(clk_sys), .rst(rst), .rd_en_n(rd_en_n), .rd_addr_en(rd_addr_en),
    .output_valid_n(output_valid_n), .bus_n(ae_bus_n), .bus_sync(empty_bus_sync),
    .take(take), .age(age), .image(ae_img));
  qrf_reader pf (.clk_sys(clk_sys), .rst(rst), .rd_en_n(rd_en_n), .rd_addr_en(rd_addr_en),
    .output_valid_n(output_valid_n), .bus_n(af_bus_n), .bus_sync(full_bus_sync),
    .take(), .age(), .image(af_img));

  initial
  begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////
  task cmp(input [35:0] got, input [35:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp)
      begin
        n_errors = n_errors + 1;
        $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task step(input integer n);
    repeat (n) @(posedge clk_sys);
  endtask
  task wsel(input [4:0] qn);
    begin
      @(posedge clk_sys);
      wr_en_n <= 1'b1;
      wr_addr_en <= 1'b1;
      write_queue_address <= qn;
      @(posedge clk_sys);
      wr_addr_en <= 1'b0;
      wq = qn;
    end
  endtask
  // model drops words to a full queue, as the device must
  task push(input [35:0] d);
    begin
      @(posedge clk_sys);
      wr_en_n <= 1'b0;
      data_in <= d;
      if (mq[wq].size() < 8)
        mq[wq].push_back(d);
    end
  endtask
  // six-word packet: start on the first, near end on the second, end on the last
  task pkt;
    begin
      for (i = 0; i < 6; i = i + 1)
      begin
        r = $random(seed);
        push({i == 5, i == 0, i == 1, r[0], $random(seed)});
      end
    end
  endtask
  task pushr(input integer n);
    repeat (n)
    begin
      r = $random(seed);
      push({r[3:0], $random(seed)});
    end
  endtask
  task rsel(input [4:0] qn);
    begin
      @(posedge clk_sys);
      wr_en_n <= 1'b1;
      rd_addr_en <= 1'b1;
      read_queue_address <= qn;
      @(posedge clk_sys);
      rd_addr_en <= 1'b0;
      prev_q = cur_q;
      cur_q = qn;
      step(3);
    end
  endtask
  task rd(input integer n);
    begin
      @(posedge clk_sys);
      rd_en_n <= 1'b0;
      step(n);
      rd_en_n <= 1'b1;
    end
  endtask
  task rr(input [7:0] a, input [31:0] exp);
    begin
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(negedge clk_sys);
      cmp(reg_rdata, exp);
    end
  endtask
  task close_out;
    begin
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  ////////////////////////////////////////
  always @(negedge clk_sys)
  begin
    if (rst)
      for (k = 0; k < 32; k = k + 1)
        mq[k].delete();
    else if (take === 1'b1)
    begin
      // a word taken at count zero left the old queue on the select edge itself
      q = (age === 2'h1 || age === 2'h0) ? prev_q : cur_q;
      w = (mq[q].size() != 0) ? mq[q].pop_front() : ~data_out;
      cmp(data_out, w);
    end
  end
  // whole run is about 170 cycles
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    n_errors = n_errors + 1;
    close_out;
  end
  initial
  begin
    step(8);
    rst <= 1'b0;
    rr(`QRF_CTRL_OFS, {29'h0, `QRF_CTRL_RST});
    rr(`QRF_OFFS_OFS, {16'h0, `QRF_PAE_RST, `QRF_PAF_RST});
    rr(8'h40, 32'h0);
    wsel(0);
    pushr(2);
    wsel(5);
    pushr(10);
    wsel(1);
    pushr(3);
    wsel(1);
    step(12);
    for (i = 0; i < 32; i = i + 1)
    begin
      ae_exp[i] = mq[i].size() > `QRF_PAE_RST;
      af_exp[i] = mq[i].size() + `QRF_PAF_RST < 8;
    end
    cmp(ae_img, ae_exp);
    cmp(af_img, af_exp);
    rr(`QRF_AFUL_OFS, ~af_exp);
    rsel(5);
    rd(4);
    rsel(1);
    rd(6);
    rsel(5);
    rd(8);
    cmp(output_valid_n, 1'b1);
    cmp(mq[0].size() + mq[1].size() + mq[5].size(), 0);
    reg_wdata <= 32'h2;
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= `QRF_CTRL_OFS;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    step(6);
    cmp({full_bus_sync, empty_bus_sync, af_bus_n, ae_bus_n}, 18'h0FF00);
    $display("test basic done");
    packet_mode_strap <= 1'b1;
    rst <= 1'b1;
    step(8);
    rst <= 1'b0;
    cur_q = 0;
    prev_q = 0;
    wsel(2);
    for (i = 0; i < 6; i = i + 1)
    begin
      r = $random(seed);
      w = {r[3:0], $random(seed)};
      w[`QRF_END_BIT] = (i == 5);
      w[`QRF_START_BIT] = (i == 0);
      w[`QRF_NEAR_END_BIT] = (i == 1);
      if (i == 5)
      begin
        rsel(2);
        step(4);
        cmp({output_valid_n, packet_ready_flag_n}, 2'h3);
      end
      push(w);
    end
    wsel(2);
    step(6);
    cmp(packet_ready_flag_n, 1'b0);
    rd(8);
    cmp(mq[2].size(), 0);
    $display("test packet done");
    wsel(3);
    pkt;
    wsel(2);
    pkt;
    wsel(2);
    step(4);
    rd_en_n <= 1'b0;
    @(negedge clk_sys);
    while (data_out[`QRF_NEAR_END_BIT] !== 1'b1)
      @(negedge clk_sys);
    // select lands with the read of the word just ahead of the end word
    step(2);
    rd_addr_en <= 1'b1;
    read_queue_address <= 5'h03;
    @(posedge clk_sys);
    rd_addr_en <= 1'b0;
    rd_en_n <= 1'b1;
    prev_q = cur_q;
    cur_q = 3;
    step(4);
    cmp(mq[2].size() + mq[3].size(), 5);
    cmp({output_valid_n, packet_ready_flag_n}, 2'h0);
    rr(`QRF_PRDY_OFS, 32'h00000008);
    rr(`QRF_STAT_OFS, 32'h00020306);
    cmp(ae_img, 32'hFFFFFFF7);
    $display("test switch done");
    close_out;
  end
endmodule
